// *** design/gpio_consts.svh ***
/*
  Offsets, field positions, reset values and fixed pin maps of the pin control crossbar.
  Assumes one 8-pin port, three digital requesters and a byte-wide register view.
*/
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// ************************************************************
// sizes
// ************************************************************
`define GPIO_NPINS 8
`define GPIO_DIG_N 3
`define GPIO_ADDR_W 8

// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_PORT_DATA 8'h00
`define OFS_PORT_DIR 8'h04
`define OFS_PIN_FEATURE 8'h08
`define OFS_XBAR_STATUS 8'h0c

// ************************************************************
// feature and status register fields
// ************************************************************
`define FEAT_PIN_LSB 0
`define FEAT_PIN_MSB 2
`define FEAT_SEL_BIT 3
`define FEAT_VAL_LSB 4
`define FEAT_VAL_MSB 5
`define STAT_ANA_LSB 8
`define STAT_ANA_MSB 15

// ************************************************************
// reset values
// ************************************************************
`define RST_PORT_DATA 8'hff
`define RST_PORT_DIR 8'h00

// ************************************************************
// digital requester pin maps: 0 serial periph, 1 two-wire, 2 crystal clock in
// ************************************************************
`define DIG_MASK_0 8'h0f
`define DIG_OUT_0 8'h0b
`define DIG_BIDI_0 8'h00
`define DIG_MASK_1 8'h0c
`define DIG_OUT_1 8'h00
`define DIG_BIDI_1 8'h0c
`define DIG_MASK_2 8'h40
`define DIG_OUT_2 8'h00
`define DIG_BIDI_2 8'h00

// ************************************************************
// analog and default connections
// ************************************************************
`define ANA_REF_MASK 8'h80
`define XOSC_ANA_MASK 8'hc0
`define UART_RX_PIN 6
`define UART_TX_PIN 5

// ************************************************************
// bus answers
// ************************************************************
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** design/gpio_pkg.sv ***
/*
  Types shared by the pin control crossbar files.
  Assumes the constants header is compiled alongside.
*/
package gpio_pkg;

  // input feature codes
  typedef enum logic [1:0] {
    IN_NOPULL = 2'h0,
    IN_PULLUP = 2'h1,
    IN_PULLDOWN = 2'h2,
    IN_OFF = 2'h3
  } in_feat_t;

  // output feature codes
  typedef enum logic {
    OUT_NORMAL = 1'h0,
    OUT_HIGH = 1'h1
  } out_feat_t;

endpackage

// *** design/gpio_pin_cell.sv ***
/*
  One pin of the crossbar: picks between processor control and a granted digital requester.
  Assumes at most one requester selects the pin and that outputs are registered by the caller.
*/
`timescale 1ns/1ps
`include "gpio_consts.svh"

module gpio_pin_cell (
  input wire logic [`GPIO_DIG_N-1:0] dig_sel,
  input wire logic [`GPIO_DIG_N-1:0] kind_out,
  input wire logic [`GPIO_DIG_N-1:0] kind_bidi,
  input wire logic [`GPIO_DIG_N-1:0] dig_out,
  input wire logic [`GPIO_DIG_N-1:0] dig_oe,
  input wire logic gpio_data,
  input wire logic gpio_dir,
  input wire gpio_pkg::in_feat_t in_feat,
  input wire gpio_pkg::out_feat_t out_feat,
  input wire logic is_tx_pin,
  input wire logic uart_txd,
  output logic drv_val,
  output logic drv_oe,
  output logic pull_up,
  output logic pull_down,
  output logic in_buf_en,
  output logic high_drive
);

  // ************************************************************
  // owner select
  // ************************************************************

  // a granted requester overrides all processor settings of the pin
  always_comb begin
    if (|dig_sel) begin
      drv_oe = |(dig_sel & (kind_out | (kind_bidi & dig_oe)));
      drv_val = |(dig_sel & dig_out);
      in_buf_en = 1'b1;
      pull_up = 1'b0;
      pull_down = 1'b0;
      high_drive = 1'b0;
    end else begin
      drv_oe = gpio_dir;
      drv_val = gpio_data & (is_tx_pin ? uart_txd : 1'b1);
      in_buf_en = (in_feat != gpio_pkg::IN_OFF);
      pull_up = (in_feat == gpio_pkg::IN_PULLUP);
      pull_down = (in_feat == gpio_pkg::IN_PULLDOWN);
      high_drive = gpio_dir && (out_feat == gpio_pkg::OUT_HIGH);
    end
  end

endmodule

// *** design/gpio_pin_control_crossbar.sv ***
/*
  Pin control crossbar for one 8-pin port with an AXI4-Lite register slave.
  Assumes requesters and converter fields run on ref_clk; pin inputs are asynchronous.
*/
// Notes on behaviour
// - data and direction registers, one bit per pin, written directly; data reads return the pin level on input pins.
// - feature writes carry pin address, input/output selector and value.
// - output features are normal drive or high drive.
// - input features: no pull, pull-up, pull-down, buffer off.
// - a granted digital requester takes the pin away from processor control.
// - granted pins get the direction the requester's signal needs.
// - a digital requester is granted only if no higher enabled one clashes.
// - digital grants are all pins or none.
// - converter and comparator connect only pins picked by channel and reference select.
// - comparator uses the converter's select fields for its pins.
// - analog clashes resolved by priority; digital use never blocks analog.
// - analog connection leaves digital direction and features untouched.
// - crystal oscillator requests analog or digital pins by its mode.
// - with no requester every pin is processor GPIO.
// - after reset every pin is a digital input.
// - default input feeds GPIO and serial receive; output ANDs with transmit.
// - serial lines idle high so the AND sharing is harmless.
`timescale 1ns/1ps
`include "gpio_consts.svh"

module gpio_pin_control_crossbar (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [`GPIO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`GPIO_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`GPIO_NPINS-1:0] pin_in,
  output logic [`GPIO_NPINS-1:0] pin_out,
  output logic [`GPIO_NPINS-1:0] pin_oe,
  output logic [`GPIO_NPINS-1:0] pin_pull_up,
  output logic [`GPIO_NPINS-1:0] pin_pull_down,
  output logic [`GPIO_NPINS-1:0] pin_in_en,
  output logic [`GPIO_NPINS-1:0] pin_high_drive,
  input wire logic spi_en,
  input wire logic twowire_en,
  input wire logic xosc_en,
  input wire logic xosc_analog_mode,
  input wire logic adc_en,
  input wire logic cmp_en,
  input wire logic [2:0] conv_channel_select,
  input wire logic conv_reference_select,
  input wire logic [`GPIO_DIG_N*`GPIO_NPINS-1:0] dig_out,
  input wire logic [`GPIO_DIG_N*`GPIO_NPINS-1:0] dig_oe,
  output logic [`GPIO_DIG_N*`GPIO_NPINS-1:0] dig_in,
  output logic [`GPIO_DIG_N-1:0] dig_grant,
  input wire logic uart_txd,
  output logic uart_rxd,
  output logic [`GPIO_NPINS-1:0] adc_pin_conn,
  output logic [`GPIO_NPINS-1:0] cmp_pin_conn,
  output logic [`GPIO_NPINS-1:0] xosc_pin_conn
);

  localparam int NP = `GPIO_NPINS;
  localparam int ND = `GPIO_DIG_N;
  localparam logic [7:0] DIG_MASK [ND] = '{`DIG_MASK_0, `DIG_MASK_1, `DIG_MASK_2};
  localparam logic [7:0] DIG_OUT [ND] = '{`DIG_OUT_0, `DIG_OUT_1, `DIG_OUT_2};
  localparam logic [7:0] DIG_BIDI [ND] = '{`DIG_BIDI_0, `DIG_BIDI_1, `DIG_BIDI_2};

  // ************************************************************
  // state
  // ************************************************************
  logic [NP-1:0] pin_meta_reg, pin_sync_reg;
  logic [NP-1:0] port_data_reg, port_data_next;
  logic [NP-1:0] port_direction_reg, port_direction_next;
  gpio_pkg::in_feat_t in_feat_reg [NP];
  gpio_pkg::in_feat_t in_feat_next [NP];
  gpio_pkg::out_feat_t out_feat_reg [NP];
  gpio_pkg::out_feat_t out_feat_next [NP];
  logic [2:0] feat_ptr_reg, feat_ptr_next;
  logic feat_sel_reg, feat_sel_next;
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [`GPIO_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [7:0] w_byte_reg, w_byte_next;
  logic w_lane_reg, w_lane_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [NP-1:0] out_reg, oe_reg, pu_reg, pd_reg, ie_reg, hd_reg;
  logic [NP-1:0] out_next, oe_next, pu_next, pd_next, ie_next, hd_next;
  logic [ND*NP-1:0] dig_in_reg, dig_in_next;
  logic [ND-1:0] grant_reg, grant_now;
  logic uart_rxd_reg, uart_rxd_next;
  logic [NP-1:0] adc_reg, adc_next, cmp_reg, cmp_next, xosc_reg, xosc_next;
  logic [ND-1:0] dig_req;
  logic [NP-1:0] ana_pins;
  logic [NP-1:0] gpio_read;

  // ************************************************************
  // pin input synchroniser
  // ************************************************************

  // two flops before any logic looks at a pin
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pin_meta_reg <= 8'hff;
      pin_sync_reg <= 8'hff;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ************************************************************
  // digital grants
  // ************************************************************

  // crystal takes its clock pin digitally only outside analog mode
  assign dig_req = {xosc_en & ~xosc_analog_mode, twowire_en, spi_en};

  // lower index wins; any shared pin with a higher enabled requester blocks the whole set
  for (genvar d = 0; d < ND; d++) begin : g_grant
    logic [ND-1:0] clash;
    for (genvar h = 0; h < ND; h++) begin : g_clash
      assign clash[h] = (h < d) && dig_req[h] && (|(DIG_MASK[h] & DIG_MASK[d]));
    end
    assign grant_now[d] = dig_req[d] && !(|clash);
  end

  // ************************************************************
  // analog connections
  // ************************************************************

  // shared pin choice of converter and comparator
  always_comb begin
    ana_pins = 8'h01 << conv_channel_select;
    if (conv_reference_select) begin
      ana_pins = ana_pins | `ANA_REF_MASK;
    end
    adc_next = adc_en ? ana_pins : 8'h00;
    cmp_next = cmp_en ? (ana_pins & ~adc_next) : 8'h00;
    xosc_next = (xosc_en && xosc_analog_mode) ? (`XOSC_ANA_MASK & ~(adc_next | cmp_next))
                                              : 8'h00;
  end

  // ************************************************************
  // per-pin drive selection
  // ************************************************************
  for (genvar p = 0; p < NP; p++) begin : g_pin
    logic [ND-1:0] sel, k_out, k_bidi, d_out, d_oe;
    for (genvar d = 0; d < ND; d++) begin : g_col
      assign sel[d] = grant_now[d] & DIG_MASK[d][p];
      assign k_out[d] = DIG_OUT[d][p];
      assign k_bidi[d] = DIG_BIDI[d][p];
      assign d_out[d] = dig_out[d*NP+p];
      assign d_oe[d] = dig_oe[d*NP+p];
      assign dig_in_next[d*NP+p] = sel[d] ? pin_sync_reg[p] : 1'b1;
    end
    gpio_pin_cell u_cell (
      .dig_sel(sel),
      .kind_out(k_out),
      .kind_bidi(k_bidi),
      .dig_out(d_out),
      .dig_oe(d_oe),
      .gpio_data(port_data_reg[p]),
      .gpio_dir(port_direction_reg[p]),
      .in_feat(in_feat_reg[p]),
      .out_feat(out_feat_reg[p]),
      .is_tx_pin(p == `UART_TX_PIN),
      .uart_txd(uart_txd),
      .drv_val(out_next[p]),
      .drv_oe(oe_next[p]),
      .pull_up(pu_next[p]),
      .pull_down(pd_next[p]),
      .in_buf_en(ie_next[p]),
      .high_drive(hd_next[p])
    );
    // output pins read back their data bit, input pins their level
    assign gpio_read[p] = port_direction_reg[p] ? port_data_reg[p] : pin_sync_reg[p];
  end

  // default receive path only while the pin is an unclaimed input
  assign uart_rxd_next = (!port_direction_reg[`UART_RX_PIN] && !dig_in_own_rx(grant_now))
                         ? pin_sync_reg[`UART_RX_PIN] : 1'b1;

  function automatic logic dig_in_own_rx(input logic [ND-1:0] g);
    logic own;
    own = 1'b0;
    for (int d = 0; d < ND; d++) begin
      own = own | (g[d] & DIG_MASK[d][`UART_RX_PIN]);
    end
    return own;
  endfunction

  // ************************************************************
  // bus write and port registers
  // ************************************************************

  // capture address and data in any order, then apply and answer
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_byte_next = w_byte_reg;
    w_lane_next = w_lane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    port_data_next = port_data_reg;
    port_direction_next = port_direction_reg;
    in_feat_next = in_feat_reg;
    out_feat_next = out_feat_reg;
    feat_ptr_next = feat_ptr_reg;
    feat_sel_next = feat_sel_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      w_byte_next = s_axi_wdata[7:0];
      w_lane_next = s_axi_wstrb[0];
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (aw_held_next && w_held_next && !bvalid_next) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `RESP_OKAY;
      if (aw_addr_next == `OFS_PORT_DATA) begin
        if (w_lane_next) begin
          port_data_next = w_byte_next;
        end
      end else if (aw_addr_next == `OFS_PORT_DIR) begin
        if (w_lane_next) begin
          port_direction_next = w_byte_next;
        end
      end else if (aw_addr_next == `OFS_PIN_FEATURE) begin
        if (w_lane_next) begin
          feat_ptr_next = w_byte_next[`FEAT_PIN_MSB:`FEAT_PIN_LSB];
          feat_sel_next = w_byte_next[`FEAT_SEL_BIT];
          if (w_byte_next[`FEAT_SEL_BIT]) begin
            out_feat_next[feat_ptr_next] =
              gpio_pkg::out_feat_t'(w_byte_next[`FEAT_VAL_LSB]);
          end else begin
            in_feat_next[feat_ptr_next] =
              gpio_pkg::in_feat_t'(w_byte_next[`FEAT_VAL_MSB:`FEAT_VAL_LSB]);
          end
        end
      end else if (aw_addr_next != `OFS_XBAR_STATUS) begin
        bresp_next = `RESP_SLVERR;
      end
    end
    awready_next = !aw_held_next && !bvalid_next;
    wready_next = !w_held_next && !bvalid_next;
  end

  // ************************************************************
  // bus read
  // ************************************************************

  // one read in flight; data is held until taken
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rdata_next = 32'h0;
      rresp_next = `RESP_OKAY;
      if (s_axi_araddr == `OFS_PORT_DATA) begin
        rdata_next[7:0] = gpio_read;
      end else if (s_axi_araddr == `OFS_PORT_DIR) begin
        rdata_next[7:0] = port_direction_reg;
      end else if (s_axi_araddr == `OFS_PIN_FEATURE) begin
        rdata_next[`FEAT_PIN_MSB:`FEAT_PIN_LSB] = feat_ptr_reg;
        rdata_next[`FEAT_SEL_BIT] = feat_sel_reg;
        rdata_next[`FEAT_VAL_MSB:`FEAT_VAL_LSB] = feat_sel_reg
          ? {1'b0, out_feat_reg[feat_ptr_reg]} : in_feat_reg[feat_ptr_reg];
      end else if (s_axi_araddr == `OFS_XBAR_STATUS) begin
        rdata_next[ND-1:0] = grant_reg;
        rdata_next[`STAT_ANA_MSB:`STAT_ANA_LSB] = adc_reg | cmp_reg | xosc_reg;
      end else begin
        rresp_next = `RESP_SLVERR;
      end
    end
    arready_next = !rvalid_next;
  end

  // ************************************************************
  // registers
  // ************************************************************

  // all pins come out of reset as buffered digital inputs
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      port_data_reg <= `RST_PORT_DATA;
      port_direction_reg <= `RST_PORT_DIR;
      for (int i = 0; i < NP; i++) begin
        in_feat_reg[i] <= gpio_pkg::IN_NOPULL;
        out_feat_reg[i] <= gpio_pkg::OUT_NORMAL;
      end
      feat_ptr_reg <= 3'h0;
      feat_sel_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= 2'h0;
      out_reg <= 8'h00;
      oe_reg <= 8'h00;
      pu_reg <= 8'h00;
      pd_reg <= 8'h00;
      ie_reg <= 8'hff;
      hd_reg <= 8'h00;
      dig_in_reg <= {ND*NP{1'b1}};
      grant_reg <= 3'h0;
      uart_rxd_reg <= 1'b1;
      adc_reg <= 8'h00;
      cmp_reg <= 8'h00;
      xosc_reg <= 8'h00;
    end else begin
      port_data_reg <= port_data_next;
      port_direction_reg <= port_direction_next;
      in_feat_reg <= in_feat_next;
      out_feat_reg <= out_feat_next;
      feat_ptr_reg <= feat_ptr_next;
      feat_sel_reg <= feat_sel_next;
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_byte_reg <= w_byte_next;
      w_lane_reg <= w_lane_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      pu_reg <= pu_next;
      pd_reg <= pd_next;
      ie_reg <= ie_next;
      hd_reg <= hd_next;
      dig_in_reg <= dig_in_next;
      grant_reg <= grant_now;
      uart_rxd_reg <= uart_rxd_next;
      adc_reg <= adc_next;
      cmp_reg <= cmp_next;
      xosc_reg <= xosc_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign pin_out = out_reg;
  assign pin_oe = oe_reg;
  assign pin_pull_up = pu_reg;
  assign pin_pull_down = pd_reg;
  assign pin_in_en = ie_reg;
  assign pin_high_drive = hd_reg;
  assign dig_in = dig_in_reg;
  assign dig_grant = grant_reg;
  assign uart_rxd = uart_rxd_reg;
  assign adc_pin_conn = adc_reg;
  assign cmp_pin_conn = cmp_reg;
  assign xosc_pin_conn = xosc_reg;

endmodule

// *** test/pin_crossbar_properties.sv ***
/*
  Port checker of the pin control crossbar, bound to its top module.
  Assumes outputs registered one cycle after their inputs.
*/
`timescale 1ns/1ps
module pin_crossbar_properties (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_in_en,
  input wire logic spi_en,
  input wire logic twowire_en,
  input wire logic xosc_en,
  input wire logic xosc_analog_mode,
  input wire logic adc_en,
  input wire logic cmp_en,
  input wire logic [2:0] conv_channel_select,
  input wire logic conv_reference_select,
  input wire logic uart_txd,
  input wire logic [2:0] dig_grant,
  input wire logic [7:0] adc_pin_conn,
  input wire logic [7:0] cmp_pin_conn
);
  logic [7:0] sel_mask;
  // pins picked by the converter select fields
  assign sel_mask = (8'h01 << conv_channel_select) | {conv_reference_select, 7'h00};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence b_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  grant_priority_a: assert property (
    $past(rst_b) |-> dig_grant[1] == $past(twowire_en && !spi_en))
    else $error("two-wire grant wrong");
  all_or_none_a: assert property (
    dig_grant[0] |-> pin_oe[3:0] == 4'hb) else $error("serial pins not all granted");
  xosc_digital_a: assert property (
    $past(rst_b) |-> dig_grant[2] == $past(xosc_en && !xosc_analog_mode))
    else $error("crystal grant wrong");
  adc_select_a: assert property (
    $past(rst_b) |-> adc_pin_conn == ($past(adc_en) ? $past(sel_mask) : 8'h00))
    else $error("converter pins wrong");
  cmp_share_a: assert property (
    $past(rst_b) |-> cmp_pin_conn == ($past(cmp_en && !adc_en) ? $past(sel_mask) : 8'h00))
    else $error("comparator pins wrong");
  reset_input_a: assert property (
    !$past(rst_b) |-> pin_oe == 8'h00 && pin_in_en == 8'hff) else $error("reset pins wrong");
  tx_and_a: assert property (
    !$past(uart_txd) |-> !pin_out[5]) else $error("transmit not anded");
  resp_drop_a: assert property (
    b_done |=> !s_axi_bvalid) else $error("write answer held");
endmodule
bind gpio_pin_control_crossbar pin_crossbar_properties chk_i (.ref_clk, .rst_b,
  .s_axi_bvalid, .s_axi_bready, .pin_out, .pin_oe, .pin_in_en, .spi_en, .twowire_en,
  .xosc_en, .xosc_analog_mode, .adc_en, .cmp_en, .conv_channel_select,
  .conv_reference_select, .uart_txd, .dig_grant, .adc_pin_conn, .cmp_pin_conn);

// *** test/periph_model.sv ***
/*
  Requester model: digital pin wishes of the three requesters and serial transmit.
  Assumes grants come registered from the crossbar.
*/
`timescale 1ns/1ps
module periph_model (
  input wire logic ref_clk,
  input wire logic [2:0] grant,
  input wire logic [7:0] out_val,
  input wire logic [7:0] oe_wish,
  input wire logic tx_level,
  output logic [23:0] dig_out,
  output logic [23:0] dig_oe,
  output logic uart_txd
);
  // an ungranted requester shows a changing pattern, never a held value
  always_comb begin
    for (int d = 0; d < 3; d++) begin
      dig_out[d*8 +: 8] = grant[d] ? out_val : {8{ref_clk}};
      dig_oe[d*8 +: 8] = grant[d] ? oe_wish : {8{ref_clk}};
    end
  end
  assign uart_txd = tx_level;
endmodule

// *** test/gpio_pin_control_crossbar_tb_top.sv ***
/*
  Self-checking bench of the pin control crossbar: register tasks and pin checks.
  Assumes the requester model and the constants header on the include path.
*/
`timescale 1ns/1ps
`include "gpio_consts.svh"
module gpio_pin_control_crossbar_tb_top;
  logic ref_clk = 1'b0, rst_b = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, spi_en = 1'b0, twowire_en = 1'b0;
  logic xosc_en = 1'b0, xosc_analog_mode = 1'b0, adc_en = 1'b0, cmp_en = 1'b0;
  logic conv_reference_select = 1'b0, tx_level = 1'b1;
  logic [2:0] conv_channel_select = 3'h0;
  logic [7:0] pin_in = 8'h1a, out_val = 8'h00, oe_wish = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic uart_txd, uart_rxd, aw_ok, w_ok;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rd;
  logic [7:0] pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_in_en, pin_high_drive;
  logic [7:0] adc_pin_conn, cmp_pin_conn, xosc_pin_conn;
  logic [23:0] dig_out, dig_oe, dig_in;
  logic [2:0] dig_grant;
  int errors = 0;
  int tests_run = 0;

  always #50 ref_clk = ~ref_clk;

  gpio_pin_control_crossbar dut (.ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe,
    .pin_pull_up, .pin_pull_down, .pin_in_en, .pin_high_drive, .spi_en, .twowire_en,
    .xosc_en, .xosc_analog_mode, .adc_en, .cmp_en, .conv_channel_select,
    .conv_reference_select, .dig_out, .dig_oe, .dig_in, .dig_grant, .uart_txd, .uart_rxd,
    .adc_pin_conn, .cmp_pin_conn, .xosc_pin_conn);
  periph_model pm (.ref_clk, .grant(dig_grant), .out_val, .oe_wish, .tx_level, .dig_out,
    .dig_oe, .uart_txd);

  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bus write: address and data offered together, each released when taken
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // bus read: result lands in rd and rr
  task rdr(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // lets pin sync and output registers settle
  task settle;
    repeat (4) @(posedge ref_clk);
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    $display("watchdog expired at %0t", $time);
    results;
  end

  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    settle;
    chk(32'(pin_oe), 32'h0);
    rdr(8'h04);
    chk(rd, 32'h0);
    $display("reset test done");
    wr(8'h04, 8'hf0);
    wr(8'h00, 8'ha5);
    settle;
    chk(32'(uart_rxd), 32'h1);
    wr(8'h04, 8'hb0);
    settle;
    chk(32'(uart_rxd), 32'h0);
    rdr(8'h04);
    chk(rd, 32'hb0);
    rdr(8'h00);
    chk(rd, 32'haa);
    chk(32'(pin_oe), 32'hb0);
    chk(32'(pin_out), 32'ha5);
    @(posedge ref_clk);
    tx_level <= 1'b0;
    settle;
    chk(32'(pin_out), 32'h85);
    tx_level <= 1'b1;
    $display("port test done");
    for (int i = 0; i < 4; i++) wr(8'h08, 8'(i * 17));
    wr(8'h08, 8'h1c);
    wr(8'h08, 8'h0d);
    settle;
    chk(32'(pin_pull_up), 32'h02);
    chk(32'(pin_pull_down), 32'h04);
    chk(32'(pin_in_en), 32'hf7);
    chk(32'(pin_high_drive), 32'h10);
    rdr(8'h08);
    chk(rd, 32'h0d);
    $display("feature test done");
    twowire_en <= 1'b1;
    oe_wish <= 8'h08;
    settle;
    chk(32'(dig_grant), 32'h2);
    chk(32'(pin_oe), 32'hb8);
    chk(32'(pin_in_en), 32'hff);
    spi_en <= 1'b1;
    out_val <= 8'h02;
    settle;
    chk(32'(dig_grant), 32'h1);
    chk(32'(pin_oe), 32'hbb);
    chk(32'(pin_pull_up | pin_pull_down), 32'h0);
    chk(32'(pin_out[1:0]), 32'h2);
    chk(32'(dig_in[15:0]), 32'hfffa);
    spi_en <= 1'b0;
    twowire_en <= 1'b0;
    settle;
    chk(32'(pin_oe), 32'hb0);
    chk(32'(pin_pull_up), 32'h02);
    $display("grant test done");
    xosc_en <= 1'b1;
    settle;
    chk(32'(dig_grant), 32'h4);
    wr(8'h08, 8'h32);
    wr(8'h08, 8'h37);
    xosc_analog_mode <= 1'b1;
    adc_en <= 1'b1;
    cmp_en <= 1'b1;
    conv_channel_select <= 3'h2;
    conv_reference_select <= 1'b1;
    settle;
    chk(32'(dig_grant), 32'h0);
    chk(32'(adc_pin_conn), 32'h84);
    chk(32'(cmp_pin_conn), 32'h0);
    chk(32'(xosc_pin_conn), 32'h40);
    chk(32'(pin_oe), 32'hb0);
    chk(32'(pin_in_en), 32'h73);
    rdr(8'h0c);
    chk(rd, 32'hc400);
    adc_en <= 1'b0;
    settle;
    chk(32'(cmp_pin_conn), 32'h84);
    rdr(8'h10);
    chk(32'(rr), 32'(`RESP_SLVERR));
    wr(8'h10, 8'h00);
    chk(32'(rr), 32'(`RESP_SLVERR));
    $display("analog test done");
    results;
  end
endmodule
